// ===== rtl/pscu_pkg.sv
// Shared constants and carrier types of the pin-scan configuration updater.
// Assumes one 10 MHz core clock and an AXI4-Lite master with 32-bit data.
package pscu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCK_HALF_NS = 500;
    localparam int SCK_HALF_CYC_I = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_HALF_CYC_I);

    ////////////////////////////////////////////////////////////////////////////
    // Selection pins and serial frame
    localparam int NUM_SEL_PINS = 8;
    localparam int WAKE_PIN = 7;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CTRL_UPD_BIT = 0;
    localparam int CTRL_RD_BIT = 1;
    localparam int CTRL_ADDR_LSB = 8;
    localparam logic [7:0] CFG_ADDR_RST = 8'h00;
    localparam int STAT_ENH_BIT = 0;
    localparam int STAT_ACT_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_PEND_BIT = 3;
    localparam int STAT_LEG_LSB = 4;
    localparam int STAT_PINS_LSB = 8;
    localparam int STAT_RDD_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Legacy operating states, one-hot
    localparam logic [3:0] LEG_SLEEP = 4'h1;
    localparam logic [3:0] LEG_TX_OOK = 4'h2;
    localparam logic [3:0] LEG_TX_ASK = 4'h4;
    localparam logic [3:0] LEG_RX = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b100
    } pscu_fsm_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } pscu_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pscu_axi_rsp_t;

    typedef struct packed {
        logic sel;
        logic sck;
        logic sck_oe;
        logic dat;
        logic dat_oe;
    } pscu_cfg_out_t;

endpackage

// ===== rtl/pscu_top.sv
// Pin-scan configuration updater: watches the host selection pins and
// rewrites the transceiver configuration over a three-wire serial port.
// Assumes selection pins, jumper and serial lines are synchronous to core_clk_i.
//
// Overview of operation
// [R01] Enhanced mode samples all eight selection pins every cycle for changes.
// [R02] A detected change starts a serial configuration rewrite without host help.
// [R03] Enhanced mode: controller alone drives select and serial clock, and serial data except in the read phase.
// [R04] Legacy mode: controller stays idle and drives nothing.
// [R05] Legacy mode: clock and data lines are undriven inputs, control bits zero and one.
// [R06] Legacy bits select sleep, on-off transmit, amplitude transmit or receive.
// [R07] Mode comes from the jumper once after reset; later changes are ignored.
// [R08] Select held low in legacy mode; chip select of the port in enhanced mode.
// [R09] Host raises the enhanced-mode select pin after power-up to start the controller.
// [R10] Without that wake pin high the controller stays inactive, issuing nothing.
// [R11] Pin value one means driven high, zero driven low.
// [R12] Host pin pattern for amplitude reception with start vector at the slower rate.
// [R13] Host toggles start-vector enable low then high to re-arm recognition.
// [R14] Faster amplitude reception uses the same pins with rate select low.
// [R15] Each written bit is captured on a rising serial clock edge.
// [R16] Every completed group of eight bits lands in one control register.
// [R17] Read bits launch on the rising edge and are sampled on the falling edge.
// [R18] Last pin sample is kept; any mismatch with the new sample triggers an update.
module pscu_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Register bus
    input wire pscu_pkg::pscu_axi_req_t axi_req_i,
    output pscu_pkg::pscu_axi_rsp_t axi_rsp_o,
    // Host pins
    input wire logic [pscu_pkg::NUM_SEL_PINS-1:0] sel_pins_i,
    input wire logic power_up_mode_jumper_i,
    // Transceiver serial port
    input wire logic cfg_sck_i,
    input wire logic cfg_dat_i,
    output pscu_pkg::pscu_cfg_out_t cfg_o,
    // Status
    output logic [3:0] legacy_state_o,
    output logic ctrl_active_o
);
    import pscu_pkg::*;

    typedef struct packed {
        pscu_fsm_t fsm;
        logic mode_known;
        logic enhanced;
        logic active;
        logic pending;
        logic rd_pending;
        logic [NUM_SEL_PINS-1:0] prev_pins;
        logic [3:0] div_cnt;
        logic [4:0] bit_cnt;
        logic [15:0] shreg;
        logic [7:0] rd_data;
        logic [7:0] cfg_addr;
        logic [3:0] legacy_state;
        pscu_cfg_out_t cfg;
        logic aw_held;
        logic w_held;
        logic [7:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        pscu_axi_rsp_t rsp;
    } pscu_state_t;

    pscu_state_t st_r;
    pscu_state_t st_nxt;
    logic changed;
    logic tick;
    logic sw_upd;
    logic sw_rd;
    logic [4:0] bit_inc;
    logic [31:0] status_w;

    function automatic logic [3:0] leg_decode(input logic bit0, input logic bit1);
        case ({bit1, bit0})
            2'h0: leg_decode = LEG_SLEEP;
            2'h1: leg_decode = LEG_TX_OOK;
            2'h2: leg_decode = LEG_TX_ASK;
            default: leg_decode = LEG_RX;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        changed = 1'b0;
        sw_upd = 1'b0;
        sw_rd = 1'b0;
        tick = (st_r.div_cnt == SCK_HALF_CYC - 4'h1);
        bit_inc = st_r.bit_cnt + 5'h01;
        status_w = 32'h0000_0000;
        status_w[STAT_ENH_BIT] = st_r.enhanced;
        status_w[STAT_ACT_BIT] = st_r.active;
        status_w[STAT_BUSY_BIT] = (st_r.fsm != ST_IDLE);
        status_w[STAT_PEND_BIT] = st_r.pending;
        status_w[STAT_LEG_LSB +: 4] = st_r.legacy_state;
        status_w[STAT_PINS_LSB +: 8] = st_r.prev_pins;
        status_w[STAT_RDD_LSB +: 8] = st_r.rd_data;

        // Write channels are held until both halves are in
        if (axi_req_i.awvalid && st_r.rsp.awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && st_r.rsp.wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = axi_req_i.wdata;
            st_nxt.wstrb = axi_req_i.wstrb;
        end
        if (st_r.rsp.bvalid && axi_req_i.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
        end
        if (st_r.aw_held && st_r.w_held && !st_r.rsp.bvalid) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp = RESP_OKAY;
            if (st_r.aw_addr[7:2] == REG_CTRL[7:2]) begin
                if (st_r.wstrb[0]) begin
                    sw_upd = st_r.wdata[CTRL_UPD_BIT];
                    sw_rd = st_r.wdata[CTRL_RD_BIT];
                end
                if (st_r.wstrb[1]) begin
                    st_nxt.cfg_addr = st_r.wdata[CTRL_ADDR_LSB +: 8];
                end
            end else if (st_r.aw_addr[7:2] != REG_STATUS[7:2]) begin
                st_nxt.rsp.bresp = RESP_SLVERR;
            end
        end
        if (st_r.rsp.rvalid && axi_req_i.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
        end
        if (axi_req_i.arvalid && st_r.rsp.arready) begin
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rresp = RESP_OKAY;
            st_nxt.rsp.rdata = 32'h0000_0000;
            if (axi_req_i.araddr[7:2] == REG_CTRL[7:2]) begin
                st_nxt.rsp.rdata[CTRL_ADDR_LSB +: 8] = st_r.cfg_addr;
            end else if (axi_req_i.araddr[7:2] == REG_STATUS[7:2]) begin
                st_nxt.rsp.rdata = status_w;
            end else begin
                st_nxt.rsp.rresp = RESP_SLVERR;
            end
        end

        // Mode is caught in the first cycle after reset and then frozen
        if (!st_r.mode_known) begin
            st_nxt.mode_known = 1'b1; // [R07]
            st_nxt.enhanced = power_up_mode_jumper_i; // [R07]
            st_nxt.prev_pins = sel_pins_i;
        end else if (!st_r.enhanced) begin
            st_nxt.cfg = '0; // [R04]
            st_nxt.legacy_state = leg_decode(cfg_sck_i, cfg_dat_i); // [R05] [R06]
        end else begin
            st_nxt.cfg.sck_oe = 1'b1; // [R03]
            changed = (sel_pins_i != st_r.prev_pins); // [R01] [R18]
            st_nxt.prev_pins = sel_pins_i; // [R18]
            if (sel_pins_i[WAKE_PIN]) begin
                st_nxt.active = 1'b1; // [R10]
            end
            case (st_r.fsm)
                ST_IDLE: begin
                    st_nxt.div_cnt = 4'h0;
                    st_nxt.bit_cnt = 5'h00;
                    st_nxt.cfg.sck = 1'b0;
                    st_nxt.cfg.dat_oe = 1'b1; // [R03]
                    if (st_r.active && st_r.pending) begin
                        st_nxt.fsm = ST_WRITE; // [R02]
                        st_nxt.pending = 1'b0;
                        st_nxt.shreg = {st_r.cfg_addr, sel_pins_i}; // [R16]
                        st_nxt.cfg.sel = 1'b1; // [R08]
                        st_nxt.cfg.dat = st_r.cfg_addr[7];
                        st_nxt.cfg.dat_oe = 1'b1;
                    end else if (st_r.active && st_r.rd_pending) begin
                        st_nxt.fsm = ST_READ;
                        st_nxt.rd_pending = 1'b0;
                        st_nxt.shreg = {st_r.cfg_addr, 8'h00};
                        st_nxt.cfg.sel = 1'b1; // [R08]
                        st_nxt.cfg.dat = st_r.cfg_addr[7];
                        st_nxt.cfg.dat_oe = 1'b1;
                    end
                end
                ST_WRITE, ST_READ: begin
                    st_nxt.div_cnt = tick ? 4'h0 : st_r.div_cnt + 4'h1;
                    if (tick && !st_r.cfg.sck) begin
                        st_nxt.cfg.sck = 1'b1; // [R15]
                    end else if (tick) begin
                        st_nxt.cfg.sck = 1'b0;
                        if (st_r.fsm == ST_READ && st_r.bit_cnt >= BYTE_BITS) begin
                            st_nxt.rd_data = {st_r.rd_data[6:0], cfg_dat_i}; // [R17]
                        end
                        st_nxt.bit_cnt = bit_inc;
                        st_nxt.shreg = {st_r.shreg[14:0], 1'b0};
                        st_nxt.cfg.dat = st_r.shreg[14];
                        if (bit_inc == FRAME_BITS) begin
                            st_nxt.fsm = ST_IDLE; // [R16]
                            st_nxt.cfg.sel = 1'b0;
                            st_nxt.cfg.dat = 1'b0;
                            st_nxt.cfg.dat_oe = 1'b1;
                        end else if (st_r.fsm == ST_READ && bit_inc >= BYTE_BITS) begin
                            st_nxt.cfg.dat_oe = 1'b0; // [R17]
                        end
                    end
                end
                default: begin
                    st_nxt.fsm = ST_IDLE;
                end
            endcase
            // Set after the start-of-frame clear so a late change is not lost
            if (st_nxt.active && (changed || sw_upd)) begin
                st_nxt.pending = 1'b1; // [R02]
            end
            if (st_nxt.active && sw_rd) begin
                st_nxt.rd_pending = 1'b1;
            end
        end

        st_nxt.rsp.awready = !st_nxt.aw_held && !st_nxt.rsp.bvalid;
        st_nxt.rsp.wready = !st_nxt.w_held && !st_nxt.rsp.bvalid;
        st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.fsm <= ST_IDLE;
            st_r.cfg_addr <= CFG_ADDR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign axi_rsp_o = st_r.rsp;
    assign cfg_o = st_r.cfg;
    assign legacy_state_o = st_r.legacy_state;
    assign ctrl_active_o = st_r.active;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_write_rise;
        (st_r.fsm == ST_WRITE) ##1 $rose(cfg_o.sck);
    endsequence

    sequence s_frame_start;
        (st_r.fsm == ST_IDLE) ##1 (st_r.fsm == ST_WRITE);
    endsequence

    chk_legacy_quiet: assert property ( // [R04]
        st_r.mode_known && !st_r.enhanced |=> !cfg_o.sck_oe && !cfg_o.dat_oe && !cfg_o.sel
    ) else $error("legacy mode drives a serial line");

    chk_legacy_ook: assert property ( // [R06]
        st_r.mode_known && !st_r.enhanced && cfg_sck_i && !cfg_dat_i
            |=> legacy_state_o == LEG_TX_OOK
    ) else $error("legacy on-off transmit not decoded");

    chk_legacy_ask: assert property ( // [R05]
        st_r.mode_known && !st_r.enhanced && !cfg_sck_i && cfg_dat_i
            |=> legacy_state_o == LEG_TX_ASK
    ) else $error("legacy amplitude transmit not decoded");

    // Sampled reset keeps the release edge itself from starting a check
    chk_jumper_taken: assert property ( // [R07]
        rst_n_i && !st_r.mode_known
            |=> st_r.mode_known && st_r.enhanced == $past(power_up_mode_jumper_i)
    ) else $error("jumper not captured after reset");

    chk_mode_frozen: assert property ( // [R07]
        st_r.mode_known |=> $stable(st_r.enhanced)
    ) else $error("mode changed after capture");

    chk_inactive_quiet: assert property ( // [R10]
        !st_r.active |-> st_r.fsm == ST_IDLE && !cfg_o.sel
    ) else $error("inactive controller issued an update");

    chk_change_seen: assert property ( // [R18]
        st_r.mode_known && st_r.enhanced && st_r.active && sel_pins_i != st_r.prev_pins
            |=> st_r.pending
    ) else $error("pin change not recorded");

    chk_update_starts: assert property ( // [R02]
        st_r.active && st_r.pending && st_r.fsm == ST_IDLE |=> st_r.fsm == ST_WRITE && cfg_o.sel
    ) else $error("pending update did not start");

    chk_sole_driver: assert property ( // [R03]
        st_r.mode_known && st_r.enhanced
            |=> cfg_o.sck_oe && (cfg_o.dat_oe || st_r.fsm == ST_READ)
                && (cfg_o.sel == (st_r.fsm != ST_IDLE))
    ) else $error("enhanced mode serial drive wrong");

    chk_bit_hold: assert property ( // [R15]
        s_write_rise |-> $stable(cfg_o.dat) && cfg_o.dat_oe
    ) else $error("write data moved at clock rise");

    chk_frame_len: assert property ( // [R16]
        s_frame_start |-> ##159 (st_r.fsm == ST_WRITE) ##1 (st_r.fsm == ST_IDLE)
    ) else $error("write frame is not sixteen bits");

    chk_read_release: assert property ( // [R17]
        st_r.fsm == ST_READ && st_r.bit_cnt >= BYTE_BITS |-> !cfg_o.dat_oe
    ) else $error("data line driven during read phase");

endmodule

// ===== verif/pscu_xcvr_model.sv
// Behavioural transceiver serial port facing the updater's config lines.
// Assumes the lines change only on core clock edges and are sampled once a cycle.
module pscu_xcvr_model #(
    parameter logic [7:0] RD_BYTE = 8'hA5
) (
    // Clock
    input wire logic clk_i,
    // Serial lines as resolved on the wire
    input wire logic sel_i,
    input wire logic sck_i,
    input wire logic dat_i,
    input wire logic host_oe_i,
    // Model drive of the data line
    output logic dat_o = 1'b0,
    output logic drv_o = 1'b0,
    // Observations
    output logic [15:0] frame_o = 16'h0000,
    output logic [7:0] byte_o = 8'h00,
    output int frames_o = 0,
    output int len_o = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sck_q = 1'b0;
    logic sel_q = 1'b0;
    logic [15:0] sh = 16'h0000;
    int bits = 0;
    int hi = 0;
    int rd = 0;
    logic rise;
    logic go;

    assign rise = sel_i && sck_i && !sck_q;
    assign go = rise && !host_oe_i && rd < 8;

    always @(posedge clk_i) begin
        sck_q <= sck_i;
        sel_q <= sel_i;
        // Released line changes every cycle so a stale bit is never read
        if (go) begin
            dat_o <= RD_BYTE[7-rd];
        end else if (!drv_o) begin
            dat_o <= ~dat_o;
        end
        if (sel_i) begin
            hi <= hi + 1;
        end
        if (!sel_i && sel_q) begin
            frames_o <= frames_o + 1;
            len_o <= hi;
            frame_o <= sh;
            hi <= 0;
            bits <= 0;
            rd <= 0;
            drv_o <= 1'b0;
        end else if (rise) begin
            sh <= {sh[14:0], dat_i};
            bits <= bits + 1;
            if (bits % 8 == 7) begin
                byte_o <= {sh[6:0], dat_i};
            end
            if (go) begin
                drv_o <= 1'b1;
                rd <= rd + 1;
            end
        end
    end
endmodule

// ===== verif/tb_pin_scan_config_updater.sv
// Self-checking bench of the pin-scan configuration updater.
// Assumes the transceiver model stands on the serial lines.
module tb_pin_scan_config_updater;
    timeunit 1ns;
    timeprecision 1ns;
    import pscu_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    pscu_axi_req_t req = '0;
    pscu_axi_rsp_t rsp;
    logic [7:0] pins = 8'h00;
    logic jumper = 1'b0;
    logic en_mode = 1'b0;
    logic ctl0 = 1'b0;
    logic ctl1 = 1'b0;
    pscu_cfg_out_t cfg;
    logic [3:0] leg;
    logic active;
    logic m_dat, m_drv, sck_line, dat_line;
    logic [15:0] m_frame;
    logic [7:0] m_byte;
    int m_frames, m_len;
    int errors = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic [1:0] rr;

    assign sck_line = cfg.sck_oe ? cfg.sck : ctl0;
    assign dat_line = cfg.dat_oe ? cfg.dat : (en_mode ? m_dat : ctl1);

    pscu_top pscu_top_i (
        .core_clk_i(core_clk),
        .rst_n_i(rst_n),
        .axi_req_i(req),
        .axi_rsp_o(rsp),
        .sel_pins_i(pins),
        .power_up_mode_jumper_i(jumper),
        .cfg_sck_i(sck_line),
        .cfg_dat_i(dat_line),
        .cfg_o(cfg),
        .legacy_state_o(leg),
        .ctrl_active_o(active)
    );

    pscu_xcvr_model pscu_xcvr_model_i (
        .clk_i(core_clk),
        .sel_i(cfg.sel),
        .sck_i(sck_line),
        .dat_i(dat_line),
        .host_oe_i(cfg.dat_oe),
        .dat_o(m_dat),
        .drv_o(m_drv),
        .frame_o(m_frame),
        .byte_o(m_byte),
        .frames_o(m_frames),
        .len_o(m_len)
    );

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic timeout;
        errors++;
        $display("Error t=%0t got=%h exp=%h", $time, 0, 1);
        conclude();
    endtask

    task automatic do_reset(input logic j);
        rst_n <= 1'b0;
        jumper <= j;
        en_mode <= j;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        int n;
        req <= '{1'b1, a, 1'b1, d, s, 1'b1, 1'b0, 8'h00, 1'b0};
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'b0;
        if (n == 50) timeout();
        check(32'(rsp.bresp), 32'(er));
        // Let an edge pass so the next transfer never reassigns the bus in this step
        @(posedge core_clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        req.rready <= 1'b0;
        d = rsp.rdata;
        r = rsp.rresp;
        if (n == 50) timeout();
        @(posedge core_clk);
    endtask

    task automatic wait_frames(input int k);
        int n;
        int f0;
        f0 = m_frames;
        for (n = 0; n < 1000 * k; n++) begin
            @(posedge core_clk);
            if (m_frames >= f0 + k) break;
        end
        if (n == 1000 * k) timeout();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic sc_legacy;
        logic [3:0] exp [4] = '{LEG_SLEEP, LEG_TX_OOK, LEG_TX_ASK, LEG_RX};
        do_reset(1'b0);
        for (int i = 0; i < 4; i++) begin
            ctl0 <= i[0];
            ctl1 <= i[1];
            pins <= 8'(i * 8'h41);
            repeat (3) @(posedge core_clk);
            check(32'(leg), 32'(exp[i]));
            check(32'(cfg), 32'h0);
        end
        jumper <= 1'b1;
        repeat (3) @(posedge core_clk);
        axi_rd(REG_STATUS, rd, rr);
        check(32'({rd[7:4], rd[0]}), 32'({LEG_RX, 1'b0}));
        check(32'(m_frames), 32'h0);
    endtask

    task automatic sc_asleep;
        pins <= 8'h04;
        do_reset(1'b1);
        pins <= 8'h05;
        jumper <= 1'b0;
        repeat (300) @(posedge core_clk);
        check(32'({active, leg}), 32'h0);
        check(32'(m_frames), 32'h0);
    endtask

    task automatic sc_wake;
        pins <= 8'hCA;
        wait_frames(1);
        check(32'(m_frame), 32'({CFG_ADDR_RST, 8'hCA}));
        check(32'(m_byte), 32'h0000_00CA);
        check(32'(m_len), 32'(FRAME_BITS) * 32'(SCK_HALF_CYC) * 2);
        check(32'(active), 32'h1);
    endtask

    task automatic sc_rearm;
        int f0;
        f0 = m_frames;
        pins <= 8'hC2;
        repeat (3) @(posedge core_clk);
        pins <= 8'hCA;
        wait_frames(2);
        check(32'(m_frame[7:0]), 32'h0000_00CA);
        repeat (300) @(posedge core_clk);
        check(32'(m_frames), 32'(f0 + 2));
        pins <= 8'h8A;
        wait_frames(1);
        check(32'(m_frame[7:0]), 32'h0000_008A);
    endtask

    task automatic sc_regs;
        axi_wr(REG_CTRL, 32'h0000_5A00, 4'h2, RESP_OKAY);
        axi_rd(REG_CTRL, rd, rr);
        check(rd, 32'h0000_5A00);
        axi_wr(REG_CTRL, 32'h0000_0001, 4'h1, RESP_OKAY);
        wait_frames(1);
        check(32'(m_frame), 32'h0000_5A8A);
        axi_wr(REG_CTRL, 32'h0000_0002, 4'h1, RESP_OKAY);
        wait_frames(1);
        check(32'(m_frame[15:8]), 32'h0000_005A);
        axi_rd(REG_STATUS, rd, rr);
        check(32'({rd[23:8], rd[1:0]}), 32'({16'hA58A, 2'b11}));
        axi_wr(REG_STATUS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        axi_wr(8'h08, 32'h0, 4'hF, RESP_SLVERR);
        axi_rd(8'h08, rd, rr);
        check({rd[29:0], rr}, {30'h0, RESP_SLVERR});
    endtask

    initial begin
        sc_legacy();
        sc_asleep();
        sc_wake();
        sc_rearm();
        sc_regs();
        conclude();
    end
endmodule
